// >>> design/csm_unit.sv
// execute unit for compare-and-step, normalise count, shifts and moves
`timescale 1ns/100ps
module csm_unit (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // decoded request from the decode stage
  input wire logic req_valid_i,
  input wire csm_pkg::csm_req_type req_i,
  // registered result to register file and data memory
  output logic res_valid_o,
  output csm_pkg::csm_res_type res_o,
  output logic len_error_o
);
  // ==========================================================================
  // operand selection
  wire logic is_cmp_step;
  wire logic is_shift;
  wire logic is_byte;
  wire logic [15:0] opnd;
  wire logic [3:0] shift_cnt;
  wire logic [15:0] sh_data;
  wire logic sh_carry;
  wire logic [15:0] step;
  wire logic [16:0] cmp_diff;
  wire logic [15:0] step_res;
  wire logic [15:0] move_res;
  wire logic [15:0] norm_res;
  wire logic len_ok;

  assign is_cmp_step = (req_i.op == csm_pkg::OP_COMPARE_THEN_DECREMENT_ONE) ||
                       (req_i.op == csm_pkg::OP_COMPARE_THEN_DECREMENT_TWO) ||
                       (req_i.op == csm_pkg::OP_COMPARE_THEN_INCREMENT_ONE) ||
                       (req_i.op == csm_pkg::OP_COMPARE_THEN_INCREMENT_TWO);
  assign is_shift = (req_i.op == csm_pkg::OP_LOGICAL_LEFT_SHIFT) ||
                    (req_i.op == csm_pkg::OP_LOGICAL_RIGHT_SHIFT) ||
                    (req_i.op == csm_pkg::OP_ROTATE_LEFTWARD) ||
                    (req_i.op == csm_pkg::OP_ROTATE_RIGHTWARD) ||
                    (req_i.op == csm_pkg::OP_SIGN_FILL_RIGHT_SHIFT);
  assign is_byte = (req_i.op == csm_pkg::OP_BYTE_TRANSFER);

  // short form carries a 4-bit immediate, zero extended
  assign opnd = (req_i.src == csm_pkg::SRC_IMM4) ? {12'h000, req_i.imm[3:0]} :
                (req_i.src == csm_pkg::SRC_IMM_LONG) ? req_i.imm : req_i.src_val;

  // only the low four count bits matter, so register counts wrap at 16
  assign shift_cnt = opnd[3:0];

  csm_shifter csm_shifter_inst (
    .data_i(req_i.dst_val),
    .count_i(shift_cnt),
    .op_i(req_i.op),
    .data_o(sh_data),
    .carry_o(sh_carry)
  );

  // ==========================================================================
  // normalise count: leading zeros before the first one bit
  function automatic logic [15:0] lead_zeros(input logic [15:0] v);
    logic [15:0] n;
    logic found;
    n = 16'h0000;
    found = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (!found && v[i]) begin
        found = 1'b1;
      end else if (!found) begin
        n = n + 16'h0001;
      end
    end
    return n;
  endfunction

  // a zero word counts as zero steps, as nothing can normalise it
  assign norm_res = (req_i.src_val == 16'h0000) ? 16'h0000 :
                    lead_zeros(req_i.src_val);

  // ==========================================================================
  // compare and step
  assign step = ((req_i.op == csm_pkg::OP_COMPARE_THEN_DECREMENT_TWO) ||
                 (req_i.op == csm_pkg::OP_COMPARE_THEN_INCREMENT_TWO)) ?
                csm_pkg::STEP_TWO : csm_pkg::STEP_ONE;
  // difference only drives flags; the step uses the old register value
  assign cmp_diff = {1'b0, req_i.dst_val} - {1'b0, opnd};
  assign step_res = ((req_i.op == csm_pkg::OP_COMPARE_THEN_DECREMENT_ONE) ||
                     (req_i.op == csm_pkg::OP_COMPARE_THEN_DECREMENT_TWO)) ?
                    req_i.dst_val - step :
                    req_i.dst_val + step;

  // ==========================================================================
  // moves: byte merges into low half, sign extension fills the upper byte
  assign move_res =
    (req_i.op == csm_pkg::OP_BYTE_TO_WORD_SIGN_EXTEND) ?
      {{8{opnd[csm_pkg::SIGN_B]}}, opnd[7:0]} :
    is_byte ? {req_i.dst_val[15:8], opnd[7:0]} :
    opnd;

  // ==========================================================================
  // pointer arithmetic
  wire logic [15:0] ptr_step = is_byte ? csm_pkg::STEP_ONE : csm_pkg::STEP_TWO;
  wire logic [15:0] ptr_pre = req_i.ptr_val - ptr_step;
  wire logic [15:0] ptr_post = req_i.ptr_val + ptr_step;
  wire logic [15:0] eff_addr =
    (req_i.ptr == csm_pkg::PTR_BASE_DISP) ? req_i.ptr_val + req_i.imm :
    (req_i.ptr == csm_pkg::PTR_DST_PRE_DEC) ? ptr_pre :
    req_i.ptr_val;
  wire logic ptr_upd = (req_i.ptr == csm_pkg::PTR_SRC_POST_INC) ||
                       (req_i.ptr == csm_pkg::PTR_DST_POST_INC) ||
                       (req_i.ptr == csm_pkg::PTR_DST_PRE_DEC);

  // ==========================================================================
  // instruction length check: shift group short, long immediates and displacements long
  // pointer forms other than base plus displacement fit in two bytes; a direct memory address needs the long form
  wire logic mem_direct = (req_i.src == csm_pkg::SRC_MEM) &&
                          (req_i.ptr == csm_pkg::PTR_NONE);
  assign len_ok =
    (is_shift || req_i.op == csm_pkg::OP_NORMALISE_COUNT) ?
      (req_i.length == csm_pkg::LEN_SHORT) :
    (req_i.ptr == csm_pkg::PTR_BASE_DISP || req_i.src == csm_pkg::SRC_IMM_LONG ||
     mem_direct) ? (req_i.length == csm_pkg::LEN_LONG) :
    (req_i.length == csm_pkg::LEN_SHORT);

  // ==========================================================================
  // next result
  csm_pkg::csm_res_type res_d;
  always_comb begin
    res_d = '0;
    res_d.addr = eff_addr;
    res_d.ptr_new = (req_i.ptr == csm_pkg::PTR_DST_PRE_DEC) ? ptr_pre : ptr_post;
    res_d.ptr_we = ptr_upd && (req_i.op == csm_pkg::OP_WORD_TRANSFER || is_byte);
    case (req_i.op)
      csm_pkg::OP_COMPARE_THEN_DECREMENT_ONE,
      csm_pkg::OP_COMPARE_THEN_DECREMENT_TWO,
      csm_pkg::OP_COMPARE_THEN_INCREMENT_ONE,
      csm_pkg::OP_COMPARE_THEN_INCREMENT_TWO: begin
        res_d.result = step_res;
        res_d.result_we = 1'b1;
        res_d.flags[csm_pkg::FLG_Z] = (cmp_diff[15:0] == 16'h0000);
        res_d.flags[csm_pkg::FLG_N] = cmp_diff[15];
        res_d.flags[csm_pkg::FLG_C] = cmp_diff[16];
        res_d.flags[csm_pkg::FLG_V] = (req_i.dst_val[15] != opnd[15]) &&
                                      (cmp_diff[15] != req_i.dst_val[15]);
        res_d.flags_we = 1'b1;
      end
      csm_pkg::OP_NORMALISE_COUNT: begin
        res_d.result = norm_res;
        res_d.result_we = 1'b1;
        res_d.flags[csm_pkg::FLG_Z] = (norm_res == 16'h0000);
        res_d.flags_we = 1'b1;
      end
      csm_pkg::OP_LOGICAL_LEFT_SHIFT,
      csm_pkg::OP_LOGICAL_RIGHT_SHIFT,
      csm_pkg::OP_ROTATE_LEFTWARD,
      csm_pkg::OP_ROTATE_RIGHTWARD,
      csm_pkg::OP_SIGN_FILL_RIGHT_SHIFT: begin
        res_d.result = sh_data;
        res_d.result_we = 1'b1;
        res_d.flags[csm_pkg::FLG_Z] = (sh_data == 16'h0000);
        res_d.flags[csm_pkg::FLG_N] = sh_data[15];
        res_d.flags[csm_pkg::FLG_C] = sh_carry;
        res_d.flags_we = 1'b1;
      end
      csm_pkg::OP_WORD_TRANSFER,
      csm_pkg::OP_BYTE_TRANSFER,
      csm_pkg::OP_BYTE_TO_WORD_SIGN_EXTEND: begin
        res_d.result = move_res;
        res_d.result_we = 1'b1;
        res_d.flags[csm_pkg::FLG_Z] = is_byte ? (move_res[7:0] == 8'h00) :
                                                 (move_res == 16'h0000);
        res_d.flags[csm_pkg::FLG_N] = is_byte ? move_res[7] : move_res[15];
        res_d.flags_we = 1'b1;
      end
      default: begin
        res_d.result_we = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // output register; a request with a bad length is dropped, not executed
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      res_valid_o <= 1'b0;
      res_o <= '0;
      len_error_o <= 1'b0;
    end else begin
      res_valid_o <= req_valid_i && len_ok && (req_i.op != csm_pkg::OP_NONE);
      res_o <= res_d;
      len_error_o <= req_valid_i && !len_ok;
    end
  end

  // ==========================================================================
  // checks
  a_step_after_cmp: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && len_ok && req_i.op == csm_pkg::OP_COMPARE_THEN_DECREMENT_TWO) |=>
    (res_o.result == $past(req_i.dst_val) - 16'h0002))
    else $error("decrement by two wrong");
  a_inc_step: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && len_ok && req_i.op == csm_pkg::OP_COMPARE_THEN_INCREMENT_ONE) |=>
    (res_o.result == $past(req_i.dst_val) + 16'h0001))
    else $error("increment by one wrong");
  a_cmp_zero_flag: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && is_cmp_step && req_i.dst_val == opnd) |=>
    res_o.flags[csm_pkg::FLG_Z])
    else $error("equal compare lost zero flag");
  a_shift_len: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && is_shift && req_i.length == csm_pkg::LEN_LONG) |=>
    (len_error_o && !res_valid_o))
    else $error("long shift accepted");
  a_sign_extend: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (res_valid_o && $past(req_i.op) == csm_pkg::OP_BYTE_TO_WORD_SIGN_EXTEND) |->
    (res_o.result[15:8] == {8{res_o.result[7]}}))
    else $error("sign extension wrong");
  a_byte_ptr: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && is_byte && req_i.ptr == csm_pkg::PTR_SRC_POST_INC) |=>
    (res_o.ptr_we && res_o.ptr_new == $past(req_i.ptr_val) + 16'h0001))
    else $error("byte pointer step wrong");
  a_pre_dec_addr: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && req_i.op == csm_pkg::OP_WORD_TRANSFER &&
     req_i.ptr == csm_pkg::PTR_DST_PRE_DEC) |=>
    (res_o.addr == $past(req_i.ptr_val) - 16'h0002 && res_o.ptr_new == res_o.addr))
    else $error("pre-decrement wrong");
  a_asr_sign: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && req_i.op == csm_pkg::OP_SIGN_FILL_RIGHT_SHIFT && req_i.dst_val[15]) |=>
    res_o.result[15])
    else $error("sign fill lost");
  a_disp_addr: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && req_i.ptr == csm_pkg::PTR_BASE_DISP) |=>
    (res_o.addr == $past(req_i.ptr_val) + $past(req_i.imm)))
    else $error("displacement address wrong");
  a_long_imm_len: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && req_i.src == csm_pkg::SRC_IMM_LONG &&
     req_i.length == csm_pkg::LEN_SHORT) |=>
    (len_error_o && !res_valid_o))
    else $error("short form with long immediate accepted");
  a_word_post_inc: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && len_ok && req_i.op == csm_pkg::OP_WORD_TRANSFER &&
     (req_i.ptr == csm_pkg::PTR_SRC_POST_INC || req_i.ptr == csm_pkg::PTR_DST_POST_INC)) |=>
    (res_o.ptr_we && res_o.ptr_new == $past(req_i.ptr_val) + 16'h0002))
    else $error("word post-increment wrong");
  a_short_indirect: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (req_valid_i && req_i.src == csm_pkg::SRC_MEM && req_i.length == csm_pkg::LEN_SHORT &&
     req_i.ptr != csm_pkg::PTR_NONE && req_i.ptr != csm_pkg::PTR_BASE_DISP &&
     (req_i.op == csm_pkg::OP_WORD_TRANSFER || req_i.op == csm_pkg::OP_BYTE_TRANSFER)) |=>
    (res_valid_o && !len_error_o))
    else $error("short indirect move refused");
  a_valid_not_error: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    res_valid_o |-> !len_error_o)
    else $error("result and length error together");
endmodule

// >>> design/csm_pkg.sv
// package of operation codes, operand forms and result carriers for the compare/shift/move unit
// ==========================================================================
package csm_pkg;

  // ==========================================================================
  // widths and constants
  localparam int WORD_W = 16;
  localparam int CNT_W = 4;
  localparam int FLAG_W = 5;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  localparam logic [2:0] LEN_SHORT = 3'h2;
  localparam logic [2:0] LEN_LONG = 3'h4;
  localparam int FLG_N = 0;
  localparam int FLG_C = 1;
  localparam int FLG_V = 2;
  localparam int FLG_Z = 3;
  localparam int FLG_E = 4;
  localparam int SIGN_B = 7;

  // ==========================================================================
  // operations
  typedef enum logic [4:0] {
    OP_NONE,
    OP_COMPARE_THEN_DECREMENT_ONE,
    OP_COMPARE_THEN_DECREMENT_TWO,
    OP_COMPARE_THEN_INCREMENT_ONE,
    OP_COMPARE_THEN_INCREMENT_TWO,
    OP_NORMALISE_COUNT,
    OP_LOGICAL_LEFT_SHIFT,
    OP_LOGICAL_RIGHT_SHIFT,
    OP_ROTATE_LEFTWARD,
    OP_ROTATE_RIGHTWARD,
    OP_SIGN_FILL_RIGHT_SHIFT,
    OP_WORD_TRANSFER,
    OP_BYTE_TRANSFER,
    OP_BYTE_TO_WORD_SIGN_EXTEND
  } csm_op_type;

  // second operand source
  typedef enum logic [2:0] {
    SRC_REG,
    SRC_IMM4,
    SRC_IMM_LONG,
    SRC_MEM
  } csm_src_type;

  // pointer side effect
  typedef enum logic [2:0] {
    PTR_NONE,
    PTR_SRC_POST_INC,
    PTR_DST_PRE_DEC,
    PTR_DST_POST_INC,
    PTR_BASE_DISP
  } csm_ptr_type;

  // decoded request
  typedef struct packed {
    csm_op_type op;
    csm_src_type src;
    csm_ptr_type ptr;
    logic [2:0] length;
    logic [15:0] dst_val;
    logic [15:0] src_val;
    logic [15:0] ptr_val;
    logic [15:0] imm;
  } csm_req_type;

  // registered result
  typedef struct packed {
    logic [15:0] result;
    logic result_we;
    logic [15:0] ptr_new;
    logic ptr_we;
    logic [15:0] addr;
    logic [FLAG_W-1:0] flags;
    logic flags_we;
  } csm_res_type;

endpackage

// >>> design/csm_shifter.sv
// barrel shifter/rotator for the compare/shift/move unit
`timescale 1ns/100ps
module csm_shifter (
  // operand and control
  input wire logic [15:0] data_i,
  input wire logic [3:0] count_i,
  input wire csm_pkg::csm_op_type op_i,
  // result
  output logic [15:0] data_o,
  output logic carry_o
);
  // ==========================================================================
  // doubled words give rotates and sign fill without loops
  wire logic [31:0] dbl_rot = {data_i, data_i};
  wire logic [31:0] dbl_sgn = {{16{data_i[15]}}, data_i};
  wire logic [31:0] left_w = {16'h0000, data_i} << count_i;
  wire logic [31:0] right_w = {data_i, 16'h0000} >> count_i;
  wire logic [31:0] rotl_w = dbl_rot << count_i;
  wire logic [31:0] rotr_w = dbl_rot >> count_i;
  wire logic [31:0] asr_w = dbl_sgn >> count_i;
  wire logic [16:0] asr_c = {dbl_sgn[15:0], 1'b0} >> count_i;

  // ==========================================================================
  // result select
  always_comb begin
    data_o = data_i;
    carry_o = 1'b0;
    case (op_i)
      csm_pkg::OP_LOGICAL_LEFT_SHIFT: begin
        data_o = left_w[15:0];
        carry_o = (count_i != 4'h0) ? left_w[16] : 1'b0;
      end
      csm_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
        data_o = right_w[31:16];
        carry_o = (count_i != 4'h0) ? right_w[15] : 1'b0;
      end
      csm_pkg::OP_ROTATE_LEFTWARD: begin
        data_o = rotl_w[31:16];
        carry_o = rotl_w[16];
      end
      csm_pkg::OP_ROTATE_RIGHTWARD: begin
        data_o = rotr_w[15:0];
        carry_o = rotr_w[15];
      end
      csm_pkg::OP_SIGN_FILL_RIGHT_SHIFT: begin
        data_o = asr_w[15:0];
        carry_o = (count_i != 4'h0) ? asr_c[0] : 1'b0;
      end
      default: begin
        data_o = data_i;
        carry_o = 1'b0;
      end
    endcase
  end
endmodule

// >>> testbench/csm_mem_model.sv
// behavioural data memory standing on the far side of the execute unit
`timescale 1ns/100ps
module csm_mem_model (
  // read port, byte address in, word out
  input wire logic [15:0] rd_addr_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem_array [0:255];

  // word read; each word differs so a wrong pointer shows up at once
  always_comb begin
    rd_data_o = mem_array[rd_addr_i[8:1]];
  end

  // fill with a pattern instead of zeros, zeros would hide missed fetches
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_array[i] = {i[7:0], ~i[7:0]};
    end
  end
endmodule

// >>> testbench/cpu_compare_shift_move_ops_test.sv
// self-checking bench for the compare, shift and move execute unit
`timescale 1ns/100ps
module cpu_compare_shift_move_ops_test;
  // ==========================================================================
  // signals, design and memory model
  typedef struct packed {
    csm_pkg::csm_req_type rq;
    logic [15:0] res;
    logic [15:0] aux;
    logic [3:0] chk;
  } csm_row_type;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic req_valid_i = 1'b0;
  csm_pkg::csm_req_type req_i = '0;
  logic res_valid_o;
  csm_pkg::csm_res_type res_o;
  logic len_error_o;
  logic [15:0] mem_addr = 16'h0000;
  logic [15:0] mem_data;
  int miscompares = 0;
  int tests_run = 0;
  csm_row_type rows [$];
  csm_row_type r;
  csm_row_type q;

  csm_unit csm_unit_inst (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .req_valid_i(req_valid_i),
    .req_i(req_i),
    .res_valid_o(res_valid_o),
    .res_o(res_o),
    .len_error_o(len_error_o)
  );
  csm_mem_model csm_mem_model_inst (
    .rd_addr_i(mem_addr),
    .rd_data_o(mem_data)
  );

  // 125 MHz clock
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================================
  // helpers
  task automatic step();
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // chk bits: 0 result, 1 pointer update, 2 result is the fetched word, 3 address
  task automatic add(csm_pkg::csm_op_type op, csm_pkg::csm_src_type s,
      csm_pkg::csm_ptr_type p, logic [2:0] n, logic [15:0] d, sv, pv, im, res, aux,
      logic [3:0] c);
    rows.push_back('{'{op, s, p, n, d, sv, pv, im}, res, aux, c});
  endtask

  // memory operands come from the model, addressed by the pointer value
  task automatic send(inout csm_row_type x);
    mem_addr = x.rq.ptr_val;
    step();
    if (x.rq.src == csm_pkg::SRC_MEM) begin
      x.rq.src_val = mem_data;
    end
    if (x.chk[2]) begin
      x.res = mem_data;
    end
    req_valid_i = 1'b1;
    req_i = x.rq;
  endtask

  task automatic expect_row(input csm_row_type x);
    cmp(res_valid_o, 1'b1);
    cmp(res_o.result_we, 1'b1);
    if (x.chk[0]) begin
      cmp(res_o.result, x.res);
    end
    if (x.chk[1]) begin
      cmp(res_o.ptr_new, x.aux);
      cmp(res_o.ptr_we, 1'b1);
    end else begin
      cmp(res_o.ptr_we, 1'b0);
    end
    if (x.chk[3]) begin
      cmp(res_o.addr, x.aux);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // run is under a hundred cycles; this cuts a hang well after that
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    miscompares++;
    $display("watchdog expired");
    end_of_test();
  end

  // ==========================================================================
  // sequence
  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1;
    cmp(res_valid_o, 1'b0);
    cmp(len_error_o, 1'b0);
    srst_i = 1'b0;
    $display("test reset done");
    add(csm_pkg::OP_COMPARE_THEN_DECREMENT_ONE, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 16'h0005, 0, 0, 16'h0003, 16'h0004, 0, 4'h1);
    add(csm_pkg::OP_COMPARE_THEN_DECREMENT_TWO, csm_pkg::SRC_IMM_LONG, csm_pkg::PTR_NONE,
        3'h4, 16'h1000, 0, 0, 16'h1234, 16'h0FFE, 0, 4'h1);
    add(csm_pkg::OP_COMPARE_THEN_INCREMENT_ONE, csm_pkg::SRC_MEM, csm_pkg::PTR_NONE,
        3'h4, 16'hFFFF, 0, 16'h0010, 0, 16'h0000, 0, 4'h1);
    add(csm_pkg::OP_COMPARE_THEN_INCREMENT_TWO, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 16'h7FFF, 0, 0, 16'hFFF1, 16'h8001, 0, 4'h1);
    add(csm_pkg::OP_NORMALISE_COUNT, csm_pkg::SRC_REG, csm_pkg::PTR_NONE,
        3'h2, 16'h0010, 16'h0010, 0, 0, 16'h000B, 0, 4'h1);
    add(csm_pkg::OP_NORMALISE_COUNT, csm_pkg::SRC_REG, csm_pkg::PTR_NONE,
        3'h2, 16'h8000, 16'h8000, 0, 0, 16'h0000, 0, 4'h1);
    add(csm_pkg::OP_LOGICAL_LEFT_SHIFT, csm_pkg::SRC_REG, csm_pkg::PTR_NONE,
        3'h2, 16'h8421, 16'h0013, 0, 0, 16'h2108, 0, 4'h1);
    add(csm_pkg::OP_LOGICAL_RIGHT_SHIFT, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 16'h8421, 0, 0, 16'h0004, 16'h0842, 0, 4'h1);
    add(csm_pkg::OP_ROTATE_LEFTWARD, csm_pkg::SRC_REG, csm_pkg::PTR_NONE,
        3'h2, 16'h8421, 16'h0001, 0, 0, 16'h0843, 0, 4'h1);
    add(csm_pkg::OP_ROTATE_RIGHTWARD, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 16'h8421, 0, 0, 16'h0004, 16'h1842, 0, 4'h1);
    add(csm_pkg::OP_SIGN_FILL_RIGHT_SHIFT, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 16'h8421, 0, 0, 16'h0004, 16'hF842, 0, 4'h1);
    add(csm_pkg::OP_WORD_TRANSFER, csm_pkg::SRC_MEM, csm_pkg::PTR_SRC_POST_INC,
        3'h2, 0, 0, 16'h0100, 0, 0, 16'h0102, 4'h7);
    add(csm_pkg::OP_WORD_TRANSFER, csm_pkg::SRC_REG, csm_pkg::PTR_DST_PRE_DEC,
        3'h2, 0, 16'h1111, 16'h0200, 0, 0, 16'h01FE, 4'hA);
    add(csm_pkg::OP_WORD_TRANSFER, csm_pkg::SRC_MEM, csm_pkg::PTR_DST_POST_INC,
        3'h2, 0, 0, 16'h0300, 0, 0, 16'h0302, 4'h2);
    add(csm_pkg::OP_BYTE_TRANSFER, csm_pkg::SRC_MEM, csm_pkg::PTR_SRC_POST_INC,
        3'h2, 0, 0, 16'h0101, 0, 0, 16'h0102, 4'h2);
    add(csm_pkg::OP_BYTE_TRANSFER, csm_pkg::SRC_REG, csm_pkg::PTR_DST_PRE_DEC,
        3'h2, 0, 16'h0055, 16'h0200, 0, 0, 16'h01FF, 4'hA);
    add(csm_pkg::OP_BYTE_TRANSFER, csm_pkg::SRC_REG, csm_pkg::PTR_DST_POST_INC,
        3'h2, 0, 16'h0055, 16'h0200, 0, 0, 16'h0201, 4'h2);
    add(csm_pkg::OP_WORD_TRANSFER, csm_pkg::SRC_MEM, csm_pkg::PTR_BASE_DISP,
        3'h4, 0, 0, 16'h1000, 16'h0234, 0, 16'h1234, 4'h8);
    add(csm_pkg::OP_WORD_TRANSFER, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 0, 0, 0, 16'hFFF9, 16'h0009, 0, 4'h1);
    add(csm_pkg::OP_WORD_TRANSFER, csm_pkg::SRC_IMM_LONG, csm_pkg::PTR_NONE,
        3'h4, 0, 0, 0, 16'hBEEF, 16'hBEEF, 0, 4'h1);
    add(csm_pkg::OP_BYTE_TRANSFER, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 16'h1234, 0, 0, 16'h000C, 16'h120C, 0, 4'h1);
    add(csm_pkg::OP_BYTE_TRANSFER, csm_pkg::SRC_IMM_LONG, csm_pkg::PTR_NONE,
        3'h4, 16'h1234, 0, 0, 16'h00A7, 16'h12A7, 0, 4'h1);
    add(csm_pkg::OP_WORD_TRANSFER, csm_pkg::SRC_MEM, csm_pkg::PTR_NONE,
        3'h4, 0, 0, 16'h0040, 0, 0, 0, 4'h5);
    add(csm_pkg::OP_BYTE_TO_WORD_SIGN_EXTEND, csm_pkg::SRC_REG, csm_pkg::PTR_NONE,
        3'h2, 0, 16'h0080, 0, 0, 16'hFF80, 0, 4'h1);
    add(csm_pkg::OP_BYTE_TO_WORD_SIGN_EXTEND, csm_pkg::SRC_REG, csm_pkg::PTR_NONE,
        3'h2, 0, 16'h127F, 0, 0, 16'h007F, 0, 4'h1);
    // table: one request at a time, answer looked at in its single cycle
    foreach (rows[i]) begin
      r = rows[i];
      send(r);
      step();
      expect_row(r);
      req_valid_i = 1'b0;
    end
    rows.delete();
    $display("test table done");
    // compare flags with two requests issued with no gap between them
    add(csm_pkg::OP_COMPARE_THEN_DECREMENT_ONE, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 16'h0003, 0, 0, 16'h0005, 16'h0002, 0, 4'h1);
    add(csm_pkg::OP_COMPARE_THEN_DECREMENT_ONE, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 16'h0005, 0, 0, 16'h0005, 16'h0004, 0, 4'h1);
    q = rows.pop_back();
    r = rows.pop_back();
    send(r);
    step();
    expect_row(r);
    cmp(res_o.flags, 5'h03);
    cmp(res_o.flags_we, 1'b1);
    req_i = q.rq;
    step();
    expect_row(q);
    cmp(res_o.flags, 5'h08);
    req_valid_i = 1'b0;
    $display("test compare flags done");
    // wrong lengths are refused and give no result
    add(csm_pkg::OP_LOGICAL_LEFT_SHIFT, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h4, 16'h0001, 0, 0, 16'h0001, 0, 0, 4'h0);
    add(csm_pkg::OP_NORMALISE_COUNT, csm_pkg::SRC_REG, csm_pkg::PTR_NONE,
        3'h4, 16'h0001, 16'h0001, 0, 0, 0, 0, 4'h0);
    add(csm_pkg::OP_COMPARE_THEN_DECREMENT_TWO, csm_pkg::SRC_IMM_LONG, csm_pkg::PTR_NONE,
        3'h2, 16'h0001, 0, 0, 16'h0100, 0, 0, 4'h0);
    add(csm_pkg::OP_WORD_TRANSFER, csm_pkg::SRC_REG, csm_pkg::PTR_BASE_DISP,
        3'h2, 0, 0, 16'h1000, 16'h0002, 0, 0, 4'h0);
    while (rows.size() > 0) begin
      r = rows.pop_front();
      send(r);
      step();
      cmp(len_error_o, 1'b1);
      cmp(res_valid_o, 1'b0);
      req_valid_i = 1'b0;
    end
    $display("test length refusal done");
    // an empty operation must produce nothing
    add(csm_pkg::OP_NONE, csm_pkg::SRC_REG, csm_pkg::PTR_NONE, 3'h2, 0, 0, 0, 0, 0, 0, 4'h0);
    r = rows.pop_back();
    send(r);
    step();
    cmp(res_valid_o, 1'b0);
    cmp(len_error_o, 1'b0);
    req_valid_i = 1'b0;
    // reset in mid-run wins over a request taken at the same edge
    add(csm_pkg::OP_WORD_TRANSFER, csm_pkg::SRC_IMM4, csm_pkg::PTR_NONE,
        3'h2, 0, 0, 0, 16'h0003, 16'h0003, 0, 4'h1);
    r = rows.pop_back();
    send(r);
    srst_i = 1'b1;
    step();
    cmp(res_valid_o, 1'b0);
    req_valid_i = 1'b0;
    step();
    srst_i = 1'b0;
    cmp(res_valid_o, 1'b0);
    // the unit must work again straight after the mid-run reset
    send(r);
    step();
    expect_row(r);
    req_valid_i = 1'b0;
    $display("test idle and reset done");
    end_of_test();
  end
endmodule
